// file: mce_defs.svh
// Register offsets, codes, reset values and counts of the motion engine register bank
`ifndef MCE_DEFS_SVH
`define MCE_DEFS_SVH

`define MCE_OFS_ENABLE    12'h100
`define MCE_OFS_SENS      12'h101
`define MCE_OFS_SC0       12'h102
`define MCE_OFS_SC1       12'h103
`define MCE_OFS_RANGE     12'h104
`define MCE_OFS_SCAN      12'h105
`define MCE_OFS_RESULT_LO 12'h10A
`define MCE_OFS_RESULT_HI 12'h10B
`define MCE_OFS_VERSION   12'h10C

`define MCE_ON_CODE       8'h11
`define MCE_OFF_CODE      8'h00

`define MCE_SC0_EXT_HI    7
`define MCE_SC0_EXT_LO    6
`define MCE_SC0_DISABLED  5
`define MCE_SC0_SUSPEND   4
`define MCE_SC0_DIRCTL    3
`define MCE_SC0_DIR       2
`define MCE_SC0_DETECTED  1
`define MCE_SC0_STABLE    0
`define MCE_SC1_TICK      7
`define MCE_SC1_RSVD      1

`define MCE_RST_BYTE      8'h00
`define MCE_RST_WORD      16'h0000
`define MCE_RST_DISABLED  1'b1

`define MCE_STABLE_CONVS  8'h40
`define MCE_STABLE_BAND   12'h020
`define MCE_THR_FLOOR     12'h010
`define MCE_BASE_SHIFT    4

`endif

// file: mce_pkg.sv
// Types shared by the motion engine register bank
package mce_pkg;

  typedef enum logic [1:0] {
    MCE_OFF = 2'b00,
    MCE_RUN = 2'b01
  } mce_state_t;

  typedef struct packed {
    mce_state_t  state;
    logic [7:0]  enable_code;
    logic [7:0]  sens;
    logic [1:0]  ext_level;
    logic        disabled;
    logic        suspend;
    logic        dir_ctl;
    logic        dir;
    logic        detected;
    logic        stable;
    logic [7:0]  sc1;
    logic [7:0]  range;
    logic [7:0]  scan;
    logic [15:0] result;
    logic [15:0] baseline;
    logic [7:0]  stable_cnt;
    logic [7:0]  rdata;
  } mce_regs_t;

endpackage

// file: mce_regs.sv
// Motion engine control and status register bank with its detection engine
`timescale 1ns/1ns
`default_nettype none
`include "mce_defs.svh"

module mce_regs #(
  parameter logic [7:0] VERSION = 8'h01 // Arbitrary value
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] host_addr,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic [7:0]  host_wdata,
  output logic      [7:0]  host_rdata,
  input  wire logic        engine_init_request,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_data,
  output logic             engine_running,
  output logic             motion_flag
);

  mce_pkg::mce_regs_t r;
  mce_pkg::mce_regs_t next_r;

  // Detection threshold from sensitivity, range and extended level
  function automatic logic [11:0] mce_threshold(
    input logic [7:0] sens,
    input logic [7:0] range,
    input logic [1:0] ext
  );
    logic [11:0] sens_term;
    logic [11:0] range_term;
    logic [11:0] ext_term;
    sens_term  = {2'h0, sens, 2'h0};
    range_term = {4'h0, range >> ext};
    ext_term   = {8'h0, ext, 2'h0};
    mce_threshold = sens_term + range_term + `MCE_THR_FLOOR - ext_term;
  endfunction

  // Magnitude of the deviation from the tracked baseline
  function automatic logic [15:0] mce_abs_diff(
    input logic [15:0] a,
    input logic [15:0] b
  );
    mce_abs_diff = (a >= b) ? (a - b) : (b - a);
  endfunction

  function automatic logic mce_hit(input logic [11:0] addr, input logic [11:0] ofs);
    mce_hit = (addr == ofs);
  endfunction

  logic [15:0] dev;
  logic [11:0] thr;
  logic        pos;

  always_comb begin
    dev = mce_abs_diff(conv_data, r.baseline);
    thr = mce_threshold(r.sens, r.range, r.ext_level);
    pos = (conv_data >= r.baseline);
    next_r = r;

    // Host writes
    if (host_wr) begin
      if (mce_hit(host_addr, `MCE_OFS_ENABLE)) begin
        next_r.enable_code = host_wdata;
      end
      if (mce_hit(host_addr, `MCE_OFS_SENS)) begin
        next_r.sens = host_wdata;
      end
      if (mce_hit(host_addr, `MCE_OFS_SC0)) begin
        next_r.ext_level = host_wdata[`MCE_SC0_EXT_HI:`MCE_SC0_EXT_LO];
        next_r.suspend   = host_wdata[`MCE_SC0_SUSPEND];
        next_r.dir_ctl   = host_wdata[`MCE_SC0_DIRCTL];
        next_r.detected  = host_wdata[`MCE_SC0_DETECTED];
      end
      if (mce_hit(host_addr, `MCE_OFS_SC1)) begin
        next_r.sc1 = host_wdata;
        next_r.sc1[`MCE_SC1_RSVD] = 1'b0;
      end
      if (mce_hit(host_addr, `MCE_OFS_RANGE)) begin
        next_r.range = host_wdata;
      end
      if (mce_hit(host_addr, `MCE_OFS_SCAN)) begin
        next_r.scan = host_wdata;
      end
    end

    // Engine
    unique case (r.state)
      mce_pkg::MCE_OFF: begin
        if (engine_init_request && r.enable_code == `MCE_ON_CODE) begin
          next_r.state      = mce_pkg::MCE_RUN;
          next_r.disabled   = 1'b0;
          next_r.stable     = 1'b0;
          next_r.dir        = 1'b0;
          next_r.stable_cnt = `MCE_RST_BYTE;
          next_r.baseline   = conv_data;
        end
      end
      mce_pkg::MCE_RUN: begin
        if (conv_done) begin
          if (r.enable_code == `MCE_OFF_CODE) begin
            next_r.state    = mce_pkg::MCE_OFF;
            next_r.disabled = 1'b1;
          end else begin
            next_r.result = conv_data;
            if (!(host_wr && mce_hit(host_addr, `MCE_OFS_SC1)
                  && host_wdata[`MCE_SC1_TICK])) begin
              next_r.sc1[`MCE_SC1_TICK] = 1'b0;
            end
            next_r.baseline = r.baseline + 16'(
              $signed({pos ? dev : -dev}) >>> `MCE_BASE_SHIFT);
            if (!r.suspend) begin
              if (!r.stable) begin
                if (dev < {4'h0, `MCE_STABLE_BAND}) begin
                  next_r.stable_cnt = r.stable_cnt + 8'h01;
                end else begin
                  next_r.stable_cnt = `MCE_RST_BYTE;
                end
                if (r.stable_cnt == `MCE_STABLE_CONVS) begin
                  next_r.stable = 1'b1;
                end
              end else if (dev > {4'h0, thr}) begin
                next_r.detected = 1'b1;
                if (!r.detected) begin
                  next_r.dir = pos;
                end
              end
            end
          end
        end
      end
    endcase

    // Registered read port
    next_r.rdata = `MCE_RST_BYTE;
    if (host_rd) begin
      unique case (host_addr)
        `MCE_OFS_ENABLE:    next_r.rdata = r.enable_code;
        `MCE_OFS_SENS:      next_r.rdata = r.sens;
        `MCE_OFS_SC0:       next_r.rdata = {r.ext_level, r.disabled, r.suspend,
                                            r.dir_ctl, r.dir, r.detected, r.stable};
        `MCE_OFS_SC1:       next_r.rdata = r.sc1;
        `MCE_OFS_RANGE:     next_r.rdata = r.range;
        `MCE_OFS_SCAN:      next_r.rdata = r.scan;
        `MCE_OFS_RESULT_LO: next_r.rdata = r.result[7:0];
        `MCE_OFS_RESULT_HI: next_r.rdata = r.result[15:8];
        `MCE_OFS_VERSION:   next_r.rdata = VERSION;
        default:            next_r.rdata = `MCE_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r.state       <= mce_pkg::MCE_OFF;
      r.enable_code <= `MCE_OFF_CODE;
      r.sens        <= `MCE_RST_BYTE;
      r.ext_level   <= 2'h0;
      r.disabled    <= `MCE_RST_DISABLED;
      r.suspend     <= 1'b0;
      r.dir_ctl     <= 1'b0;
      r.dir         <= 1'b0;
      r.detected    <= 1'b0;
      r.stable      <= 1'b0;
      r.sc1         <= `MCE_RST_BYTE;
      r.range       <= `MCE_RST_BYTE;
      r.scan        <= `MCE_RST_BYTE;
      r.result      <= `MCE_RST_WORD;
      r.baseline    <= `MCE_RST_WORD;
      r.stable_cnt  <= `MCE_RST_BYTE;
      r.rdata       <= `MCE_RST_BYTE;
    end else begin
      r <= next_r;
    end
  end

  assign host_rdata     = r.rdata;
  // Run state is the only code with bit 0 set, so the state flop drives the pin directly
  assign engine_running = r.state[0];
  assign motion_flag    = r.detected;

endmodule
`default_nettype wire

// file: mce_regs_chk.sv
// Port assertions for the motion engine register bank
`timescale 1ns/1ns
`default_nettype none
module mce_regs_chk (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [11:0] host_addr,
  input wire logic        host_wr,
  input wire logic        host_rd,
  input wire logic [7:0]  host_wdata,
  input wire logic [7:0]  host_rdata,
  input wire logic        engine_init_request,
  input wire logic        conv_done,
  input wire logic [15:0] conv_data,
  input wire logic        engine_running,
  input wire logic        motion_flag
);
  logic [7:0] en_q;
  wire logic  sc0_wr = host_wr && host_addr == 12'h102;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Shadow of the enable register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      en_q <= 8'h00;
    else if (host_wr && host_addr == 12'h100)
      en_q <= host_wdata;
  end
  a_init_start: assert property (engine_init_request && !engine_running && en_q == 8'h11
    |=> engine_running) else $error("init with on code did not start");
  a_init_refused: assert property (engine_init_request && !engine_running && en_q != 8'h11
    |=> !engine_running) else $error("init without on code started");
  a_off_at_conv: assert property (engine_running && conv_done && en_q == 8'h00
    |=> !engine_running) else $error("off code not taken at conversion");
  a_run_holds: assert property (engine_running && !(conv_done && en_q == 8'h00)
    |=> engine_running) else $error("engine stopped without cause");
  a_rd_idle: assert property (!host_rd |=> host_rdata == 8'h00)
    else $error("read data not idle");
  a_rd_enable: assert property (host_rd && host_addr == 12'h100
    |=> host_rdata == $past(en_q)) else $error("enable readback wrong");
  a_off_quiet: assert property (!engine_running && !motion_flag && !sc0_wr
    |=> !motion_flag) else $error("motion set while off");
  a_flag_held: assert property (motion_flag && !sc0_wr |=> motion_flag)
    else $error("motion flag cleared by engine");
  cover property (engine_running && conv_done);
  cover property (!motion_flag ##1 motion_flag);
  cover property ($fell(engine_running));
endmodule
bind mce_regs mce_regs_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .host_addr(host_addr),
  .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
  .engine_init_request(engine_init_request), .conv_done(conv_done), .conv_data(conv_data),
  .engine_running(engine_running), .motion_flag(motion_flag));
`default_nettype wire

// file: tb_motion_engine_control_regs.sv
// Directed testbench for the motion engine register bank
`timescale 1ns/1ns
`default_nettype none
module tb_motion_engine_control_regs;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] host_addr = 12'h000;
  logic        host_wr = 1'b0;
  logic        host_rd = 1'b0;
  logic [7:0]  host_wdata = 8'h00;
  logic [7:0]  host_rdata;
  logic        init_req = 1'b0;
  logic        conv_done = 1'b0;
  logic [15:0] conv_data = 16'h8000;
  logic        engine_running;
  logic        motion_flag;
  int          mismatches = 0;
  int          samples_checked = 0;
  always #5 core_clk = ~core_clk;
  mce_regs u_dut (.core_clk(core_clk), .rst_n(rst_n), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .engine_init_request(init_req), .conv_done(conv_done), .conv_data(conv_data),
    .engine_running(engine_running), .motion_flag(motion_flag));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge core_clk);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge core_clk);
    host_wr = 1'b0;
  endtask
  // Read data is registered, so it is looked at in the cycle after the read edge
  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    @(negedge core_clk);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge core_clk);
    host_rd = 1'b0;
    chk(host_rdata & m, e);
  endtask
  task automatic conv(input logic [15:0] v);
    @(negedge core_clk);
    conv_data = v;
    conv_done = 1'b1;
    @(negedge core_clk);
    conv_done = 1'b0;
  endtask
  task automatic init_pulse();
    @(negedge core_clk);
    init_req = 1'b1;
    @(negedge core_clk);
    init_req = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic t_regs();
    rd(12'h100, 8'hFF, 8'h00);
    rd(12'h102, 8'hFF, 8'h20);
    wr(12'h101, 8'h3F);
    rd(12'h101, 8'hFF, 8'h3F);
    rd(12'h106, 8'hFF, 8'h00);
  endtask
  task automatic t_start();
    wr(12'h100, 8'h11);
    init_pulse();
    chk({7'h00, engine_running}, 8'h01);
    rd(12'h102, 8'hFF, 8'h00);
  endtask
  task automatic t_motion();
    repeat (70) conv(16'h8000);
    rd(12'h102, 8'hFF, 8'h01);
    conv(16'h9000);
    chk({7'h00, motion_flag}, 8'h01);
    rd(12'h102, 8'hFF, 8'h07);
    rd(12'h10A, 8'hFF, 8'h00);
    rd(12'h10B, 8'hFF, 8'h90);
  endtask
  task automatic t_suspend();
    wr(12'h102, 8'h10);
    chk({7'h00, motion_flag}, 8'h00);
    conv(16'h9000);
    chk({7'h00, motion_flag}, 8'h00);
    wr(12'h102, 8'h00);
    conv(16'h9000);
    chk({7'h00, motion_flag}, 8'h01);
  endtask
  task automatic t_disable();
    wr(12'h100, 8'h00);
    chk({7'h00, engine_running}, 8'h01);
    conv(16'h9000);
    chk({7'h00, engine_running}, 8'h00);
    rd(12'h102, 8'h20, 8'h20);
    wr(12'h100, 8'h55);
    rd(12'h100, 8'hFF, 8'h55);
    init_pulse();
    chk({7'h00, engine_running}, 8'h00);
    conv(16'h1234);
    rd(12'h10A, 8'hFF, 8'h00);
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    t_regs();
    t_start();
    t_motion();
    t_suspend();
    t_disable();
    report_and_stop();
  end
  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire
